// ==== design/ufm_bit_voter.sv ====
// Pin synchroniser and three-sample bit judgement.
// Assumes strobes come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "ufm_params.svh"
module ufm_bit_voter
    import ufm_pkg::*;
#(
    parameter logic RST_LEVEL = `UFM_RST_LINE
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic pinIn,
    input wire logic sampleStrobe,
    input wire logic sampleLast,
    input wire logic singleSample,
    output logic pinLevel,
    output logic bitValue,
    output logic bitNoisy,
    output logic bitDone
);
    // ----------------------------------------
    // Synchroniser, change taken when stages two and three agree
    // ----------------------------------------
    logic syncA, syncB, syncC;
    logic [2:0] samples;
    logic next_pinLevel, next_bitValue, next_bitNoisy, next_bitDone;
    logic [2:0] next_samples;
    logic [2:0] votes;

    always_comb begin
        next_pinLevel = (syncB == syncC) ? syncC : pinLevel;
        votes = {samples[1:0], pinLevel};
        next_samples = sampleStrobe ? votes : samples;
        next_bitDone = sampleStrobe & sampleLast;
        next_bitValue = bitValue;
        next_bitNoisy = bitNoisy;
        if (sampleStrobe && sampleLast) begin
            if (singleSample) begin
                // Middle sample only; line assumed clean
                next_bitValue = votes[1];
                next_bitNoisy = 1'h0;
            end else begin
                next_bitValue = (votes[0] & votes[1]) | (votes[1] & votes[2]) |
                    (votes[0] & votes[2]);
                next_bitNoisy = ~((&votes) | ~(|votes));
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            syncA <= RST_LEVEL;
            syncB <= RST_LEVEL;
            syncC <= RST_LEVEL;
            pinLevel <= RST_LEVEL;
            samples <= 3'h7;
            bitValue <= 1'h1;
            bitNoisy <= 1'h0;
            bitDone <= 1'h0;
        end else begin
            syncA <= pinIn;
            syncB <= syncA;
            syncC <= syncB;
            pinLevel <= next_pinLevel;
            samples <= next_samples;
            bitValue <= next_bitValue;
            bitNoisy <= next_bitNoisy;
            bitDone <= next_bitDone;
        end
    end
endmodule
`default_nettype wire

// ==== design/ufm_params.svh ====
// Timing counts, field positions and reset values for the receiver.
// Assumes inclusion by bare name from the design files only.
`ifndef UFM_PARAMS_SVH
`define UFM_PARAMS_SVH

// ----------------------------------------
// Oversampling
// ----------------------------------------
`define UFM_LAST_SMP8 4'h7
`define UFM_LAST_SMP16 4'hF
`define UFM_VOTE_FIRST8 4'h2
`define UFM_VOTE_FIRST16 4'h6
`define UFM_IDLE_SHIFT8 4'h3
`define UFM_IDLE_SHIFT16 4'h4

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define UFM_STOP_WL8 4'h9
`define UFM_STOP_WL9 4'hA
`define UFM_ADDR_LSB 0
`define UFM_ADDR_MSB 3
`define UFM_DIV_INT_LSB 4
`define UFM_DIV_INT_MSB 15

// ----------------------------------------
// Reset values
// ----------------------------------------
`define UFM_RST_DATA 9'h000
`define UFM_RST_LINE 1'h1

`endif

// ==== design/ufm_pkg.sv ====
// Types shared by the receiver design files.
// Assumes nothing beyond a SystemVerilog compiler.
package ufm_pkg;
    typedef enum logic {UFM_ST_IDLE, UFM_ST_FRAME} ufm_state_e;
endpackage

// ==== design/ufm_receiver.sv ====
// Serial receiver with status flags, flow control and mute mode.
// Assumes software strobes (reads, clears) are one-cycle pulses on this clock.
`timescale 1ns/1ps
`default_nettype none
`include "ufm_params.svh"
module ufm_receiver
    import ufm_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic rxPin,
    input wire logic clear_to_send_in,
    input wire logic unit_enable,
    input wire logic receiveEnable,
    input wire logic oversample8,
    input wire logic single_sample_mode,
    input wire logic word_length_select,
    input wire logic parity_check_enable,
    input wire logic parityOdd,
    input wire logic wake_method_select,
    input wire logic [3:0] nodeAddress,
    input wire logic [15:0] baudDivider,
    input wire logic rx_dma_enable,
    input wire logic tx_dma_enable,
    input wire logic error_irq_enable,
    input wire logic rx_buf_full_irq_en,
    input wire logic parity_error_irq_en,
    input wire logic transmit_complete_irq_en,
    input wire logic clear_change_irq_en,
    input wire logic request_flow_enable,
    input wire logic clear_flow_enable,
    input wire logic dataRead,
    input wire logic errorClear,
    input wire logic idleClear,
    input wire logic muteSet,
    input wire logic muteClear,
    input wire logic clearChangeClear,
    input wire logic transmitCompleteClear,
    input wire logic tx_buf_empty_flag,
    input wire logic txFrameDone,
    output logic [8:0] rxData,
    output logic rx_buf_full_flag,
    output logic noise_error_flag,
    output logic parity_error_flag,
    output logic framing_error_flag,
    output logic overrun_flag,
    output logic idle_detected_flag,
    output logic mute_request,
    output logic request_to_send_out,
    output logic clear_change_flag,
    output logic transmit_complete_flag,
    output logic txMayStart,
    output logic rxDmaRequest,
    output logic txDmaRequest,
    output logic interruptOut
);
    // ----------------------------------------
    // Bit recovery
    // ----------------------------------------
    logic pinLevel, bitValue, bitNoisy, bitDone;
    logic clearLevel, sampleStrobe, sampleLast;

    ufm_bit_voter rxVoter (
        .clock(clock),
        .rstn(rstn),
        .pinIn(rxPin),
        .sampleStrobe(sampleStrobe),
        .sampleLast(sampleLast),
        .singleSample(single_sample_mode),
        .pinLevel(pinLevel),
        .bitValue(bitValue),
        .bitNoisy(bitNoisy),
        .bitDone(bitDone)
    );

    // Only the synchroniser is used here; no strobes. Resets to the pin's
    // idle low level so release of reset shows no false toggle
    ufm_bit_voter #(.RST_LEVEL(1'h0)) clearVoter (
        .clock(clock),
        .rstn(rstn),
        .pinIn(clear_to_send_in),
        .sampleStrobe(1'h0),
        .sampleLast(1'h0),
        .singleSample(1'h0),
        .pinLevel(clearLevel),
        .bitValue(),
        .bitNoisy(),
        .bitDone()
    );

    // ----------------------------------------
    // Oversampling tick and frame sequencer
    // ----------------------------------------
    ufm_state_e state, next_state;
    logic [11:0] baudCount, next_baudCount, divInt;
    logic [3:0] sampleCount, next_sampleCount, bitIndex, next_bitIndex;
    logic [3:0] lastSample, voteFirst, stopIndex, idleShift;
    logic [7:0] idleCount, next_idleCount, idleLength;
    logic [8:0] word, next_word;
    logic noiseAcc, next_noiseAcc, prevLevel, idleArmed, next_idleArmed;
    logic tick, running, frameDone, idleEvent;

    always_comb begin
        divInt = baudDivider[`UFM_DIV_INT_MSB:`UFM_DIV_INT_LSB];
        // Fraction ignored: worst-case drift of one clock per tick
        tick = (divInt == 12'h000) || (baudCount >= divInt - 12'h001);
        next_baudCount = tick ? 12'h000 : baudCount + 12'h001;
        lastSample = oversample8 ? `UFM_LAST_SMP8 : `UFM_LAST_SMP16;
        voteFirst = oversample8 ? `UFM_VOTE_FIRST8 : `UFM_VOTE_FIRST16;
        idleShift = oversample8 ? `UFM_IDLE_SHIFT8 : `UFM_IDLE_SHIFT16;
        stopIndex = word_length_select ? `UFM_STOP_WL9 : `UFM_STOP_WL8;
        idleLength = 8'({4'h0, stopIndex + 4'h1} << idleShift);
        running = unit_enable & receiveEnable;
        sampleStrobe = (state == UFM_ST_FRAME) && tick && (sampleCount >= voteFirst) &&
            (sampleCount <= voteFirst + 4'h2);
        sampleLast = sampleCount == voteFirst + 4'h2;
        next_state = state;
        next_sampleCount = sampleCount;
        next_bitIndex = bitIndex;
        next_word = word;
        next_noiseAcc = noiseAcc;
        next_idleCount = idleCount;
        next_idleArmed = idleArmed;
        frameDone = 1'h0;
        idleEvent = 1'h0;
        unique case (state)
            UFM_ST_IDLE: begin
                if (!pinLevel) begin
                    next_idleCount = 8'h00;
                end else if (tick && idleCount != idleLength) begin
                    next_idleCount = idleCount + 8'h01;
                end
                if (tick && pinLevel && idleCount == idleLength - 8'h01 && idleArmed) begin
                    idleEvent = 1'h1;
                    next_idleArmed = 1'h0;
                end
                if (running && prevLevel && !pinLevel) begin
                    next_state = UFM_ST_FRAME;
                    next_sampleCount = 4'h0;
                    next_bitIndex = 4'h0;
                    next_noiseAcc = 1'h0;
                    next_word = `UFM_RST_DATA;
                end
            end
            UFM_ST_FRAME: begin
                if (tick) begin
                    next_sampleCount = (sampleCount == lastSample) ? 4'h0 :
                        sampleCount + 4'h1;
                    if (sampleCount == lastSample) begin
                        next_bitIndex = bitIndex + 4'h1;
                    end
                end
                if (bitDone) begin
                    next_noiseAcc = noiseAcc | bitNoisy;
                    if (bitIndex == 4'h0 && bitValue) begin
                        next_state = UFM_ST_IDLE;
                    end else if (bitIndex == stopIndex) begin
                        frameDone = 1'h1;
                        next_state = UFM_ST_IDLE;
                        next_idleArmed = 1'h1;
                        next_idleCount = 8'h00;
                    end else if (bitIndex != 4'h0) begin
                        next_word[bitIndex - 4'h1] = bitValue;
                    end
                end
                if (!running) begin
                    // Frame dropped if the receiver is switched off mid-frame
                    next_state = UFM_ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state <= UFM_ST_IDLE;
            baudCount <= 12'h000;
            sampleCount <= 4'h0;
            bitIndex <= 4'h0;
            word <= `UFM_RST_DATA;
            noiseAcc <= 1'h0;
            idleCount <= 8'h00;
            idleArmed <= 1'h0;
            prevLevel <= `UFM_RST_LINE;
        end else begin
            state <= next_state;
            baudCount <= next_baudCount;
            sampleCount <= next_sampleCount;
            bitIndex <= next_bitIndex;
            word <= next_word;
            noiseAcc <= next_noiseAcc;
            idleCount <= next_idleCount;
            idleArmed <= next_idleArmed;
            prevLevel <= pinLevel;
        end
    end

    // ----------------------------------------
    // Frame judgement and status flags
    // ----------------------------------------
    logic topBit, addrFlag, parityBad, addrFrame, addrMatch, accept, store;
    logic next_rxBuf, next_noise, next_parity, next_framing, next_overrun;
    logic next_idleFlag, next_mute, next_clearChange, next_tc, next_irq, prevClear;
    logic [8:0] next_rxData;

    always_comb begin
        topBit = word_length_select ? word[8] : word[7];
        // With parity on, the flag sits just below the parity bit
        addrFlag = parity_check_enable ? (word_length_select ? word[7] : word[6]) :
            topBit;
        parityBad = parity_check_enable &&
            ((word_length_select ? ^word : ^word[7:0]) ^ parityOdd);
        addrFrame = wake_method_select && addrFlag;
        addrMatch = word[`UFM_ADDR_MSB:`UFM_ADDR_LSB] == nodeAddress;
        next_mute = mute_request;
        if (muteSet) begin
            next_mute = 1'h1;
        end
        if (muteClear) begin
            next_mute = 1'h0;
        end
        accept = 1'h0;
        if (frameDone) begin
            if (addrFrame) begin
                accept = addrMatch;
                next_mute = !addrMatch;
            end else begin
                accept = !mute_request;
            end
        end
        if (idleEvent && mute_request && !wake_method_select) begin
            next_mute = 1'h0;
        end
        store = accept && !rx_buf_full_flag;
        next_rxData = store ? word : rxData;
        next_rxBuf = (rx_buf_full_flag && !dataRead) || store;
        // Stop bit noise is still in bitNoisy, not yet in the accumulator
        next_noise = (noise_error_flag && !errorClear) ||
            (store && (noiseAcc || bitNoisy));
        next_parity = (parity_error_flag && !errorClear) || (store && parityBad);
        next_framing = (framing_error_flag && !errorClear) ||
            (store && !bitValue);
        next_overrun = (overrun_flag && !errorClear) ||
            (accept && rx_buf_full_flag);
        next_idleFlag = (idle_detected_flag && !idleClear) ||
            (idleEvent && !mute_request);
        next_clearChange = (clear_change_flag && !clearChangeClear) ||
            (clear_flow_enable && clearLevel != prevClear);
        next_tc = (transmit_complete_flag && !transmitCompleteClear) ||
            (txFrameDone && tx_buf_empty_flag);
        next_irq = (rx_buf_full_irq_en && (next_rxBuf || next_overrun)) ||
            (parity_error_irq_en && next_parity) ||
            (error_irq_enable && rx_dma_enable &&
            (next_noise || next_framing || next_overrun)) ||
            (transmit_complete_irq_en && next_tc) ||
            (clear_change_irq_en && next_clearChange);
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rxData <= `UFM_RST_DATA;
            rx_buf_full_flag <= 1'h0;
            noise_error_flag <= 1'h0;
            parity_error_flag <= 1'h0;
            framing_error_flag <= 1'h0;
            overrun_flag <= 1'h0;
            idle_detected_flag <= 1'h0;
            mute_request <= 1'h0;
            request_to_send_out <= 1'h0;
            clear_change_flag <= 1'h0;
            transmit_complete_flag <= 1'h0;
            txMayStart <= 1'h0;
            rxDmaRequest <= 1'h0;
            txDmaRequest <= 1'h0;
            interruptOut <= 1'h0;
            prevClear <= 1'h0;
        end else begin
            rxData <= next_rxData;
            rx_buf_full_flag <= next_rxBuf;
            noise_error_flag <= next_noise;
            parity_error_flag <= next_parity;
            framing_error_flag <= next_framing;
            overrun_flag <= next_overrun;
            idle_detected_flag <= next_idleFlag;
            mute_request <= next_mute;
            request_to_send_out <= request_flow_enable && next_rxBuf;
            clear_change_flag <= next_clearChange;
            transmit_complete_flag <= next_tc;
            // Transmitter checks this only at frame start, so a rise mid-frame
            // lets that frame finish
            txMayStart <= !clear_flow_enable || !clearLevel;
            rxDmaRequest <= rx_dma_enable && next_rxBuf;
            txDmaRequest <= tx_dma_enable && tx_buf_empty_flag;
            interruptOut <= next_irq;
            prevClear <= clearLevel;
        end
    end
endmodule
`default_nettype wire

// ==== tb/test_uart_receiver_flow_mute.sv ====
// Self-checking bench for the receiver with flow control and mute.
// Assumes package, design, line node and monitor compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_uart_receiver_flow_mute;
    import ufm_pkg::*;
    // --------
    // Signals
    // --------
    logic clock = 1'h0;
    logic rstn = 1'h0;
    logic rxPin, clear_to_send_in, unit_enable, receiveEnable, oversample8;
    logic single_sample_mode, word_length_select, parity_check_enable, parityOdd;
    logic wake_method_select, rx_dma_enable, tx_dma_enable, error_irq_enable;
    logic rx_buf_full_irq_en, parity_error_irq_en, transmit_complete_irq_en;
    logic clear_change_irq_en, request_flow_enable, clear_flow_enable, dataRead;
    logic errorClear, idleClear, muteSet, muteClear, clearChangeClear;
    logic transmitCompleteClear, tx_buf_empty_flag, txFrameDone;
    logic [3:0] nodeAddress;
    logic [15:0] baudDivider;
    logic [8:0] rxData;
    logic rx_buf_full_flag, noise_error_flag, parity_error_flag, framing_error_flag;
    logic overrun_flag, idle_detected_flag, mute_request, request_to_send_out;
    logic clear_change_flag, transmit_complete_flag, txMayStart, rxDmaRequest;
    logic txDmaRequest, interruptOut;
    int n_errors = 0;
    int cmp_count = 0;
    int cycles = 0;

    ufm_receiver dut (.*);
    ufm_line_node #(.BIT_CLK(8)) node (
        .clock(clock),
        .rtsIn(request_to_send_out),
        .txLine(rxPin),
        .ctsOut(clear_to_send_in)
    );

    always #2.5 clock = ~clock;
    // Hang guard, well above the few thousand cycles the run needs
    always @(posedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            results();
        end
    end
    // --------
    // Helpers
    // --------
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic readData();
        dataRead = 1'h1;
        tick(1);
        dataRead = 1'h0;
        tick(1);
    endtask
    task automatic clearErrors();
        errorClear = 1'h1;
        tick(1);
        errorClear = 1'h0;
        tick(1);
    endtask
    task automatic results();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // --------
    // Scenarios
    // --------
    task automatic sPlain();
        {rx_dma_enable, request_flow_enable, rx_buf_full_irq_en} = 3'h7;
        node.sendFrame(9'h0A5, 8, 1'h1, -1);
        check("data", rxData, 9'h0A5);
        check("full", rx_buf_full_flag, 1'h1);
        check("rts", request_to_send_out, 1'h1);
        check("dmaReq", rxDmaRequest, 1'h1);
        check("irq", interruptOut, 1'h1);
        readData();
        check("full", rx_buf_full_flag, 1'h0);
        check("rts", request_to_send_out, 1'h0);
        {rx_dma_enable, request_flow_enable, rx_buf_full_irq_en} = 3'h0;
    endtask
    task automatic sErrors();
        {rx_dma_enable, error_irq_enable} = 2'h3;
        node.sendFrame(9'h03C, 8, 1'h1, 3);
        check("data", rxData, 9'h03C);
        check("noise", noise_error_flag, 1'h1);
        check("irq", interruptOut, 1'h1);
        readData();
        clearErrors();
        single_sample_mode = 1'h1;
        node.sendFrame(9'h03C, 8, 1'h1, 3);
        check("noise", noise_error_flag, 1'h0);
        readData();
        single_sample_mode = 1'h0;
        node.sendFrame(9'h055, 8, 1'h0, -1);
        check("framing", framing_error_flag, 1'h1);
        check("irq", interruptOut, 1'h1);
        readData();
        clearErrors();
        {rx_dma_enable, error_irq_enable} = 2'h0;
    endtask
    task automatic sParity();
        {parity_check_enable, parity_error_irq_en} = 2'h3;
        for (int k = 0; k < 4; k++) begin
            parityOdd = k[1];
            node.sendFrame({1'h0, k[0], 7'h03}, 8, 1'h1, -1);
            check("parity", parity_error_flag, k[0] ^ k[1]);
            check("irq", interruptOut, k[0] ^ k[1]);
            readData();
            clearErrors();
        end
        {parity_check_enable, parity_error_irq_en, parityOdd} = 3'h0;
    endtask
    task automatic sOverrunNine();
        rx_buf_full_irq_en = 1'h1;
        node.sendFrame(9'h011, 8, 1'h1, -1);
        check("overrun", overrun_flag, 1'h0);
        node.sendFrame(9'h022, 8, 1'h1, -1);
        check("overrun", overrun_flag, 1'h1);
        check("data", rxData, 9'h011);
        check("irq", interruptOut, 1'h1);
        check("rts", request_to_send_out, 1'h0);
        readData();
        clearErrors();
        rx_buf_full_irq_en = 1'h0;
        word_length_select = 1'h1;
        node.sendFrame(9'h1A5, 9, 1'h1, -1);
        check("data9", rxData, 9'h1A5);
        readData();
        word_length_select = 1'h0;
        oversample8 = 1'h0;
        node.bitClk = 16;
        node.sendFrame(9'h0C3, 8, 1'h1, -1);
        check("data16", rxData, 9'h0C3);
        readData();
        oversample8 = 1'h1;
        node.bitClk = 8;
    endtask
    task automatic sAddress();
        wake_method_select = 1'h1;
        nodeAddress = 4'h5;
        node.sendFrame(9'h0A3, 8, 1'h1, -1);
        check("mute", mute_request, 1'h1);
        check("full", rx_buf_full_flag, 1'h0);
        node.sendFrame(9'h015, 8, 1'h1, -1);
        check("full", rx_buf_full_flag, 1'h0);
        muteClear = 1'h1;
        tick(1);
        muteClear = 1'h0;
        tick(1);
        check("mute", mute_request, 1'h0);
        muteSet = 1'h1;
        tick(1);
        muteSet = 1'h0;
        {parity_check_enable, parityOdd} = 2'h3;
        node.sendFrame(9'h045, 8, 1'h1, -1);
        check("mute", mute_request, 1'h0);
        check("full", rx_buf_full_flag, 1'h1);
        check("parity", parity_error_flag, 1'h0);
        readData();
        {parity_check_enable, parityOdd, wake_method_select} = 3'h0;
    endtask
    task automatic sIdle();
        node.sendFrame(9'h05A, 8, 1'h1, -1);
        readData();
        {idleClear, muteSet} = 2'h3;
        tick(1);
        {idleClear, muteSet} = 2'h0;
        // Idle span is ten bits of eight ticks after the frame
        tick(100);
        check("mute", mute_request, 1'h0);
        check("idle", idle_detected_flag, 1'h0);
    endtask
    task automatic sFlowTx();
        {clear_flow_enable, clear_change_irq_en} = 2'h3;
        tick(10);
        check("mayStart", txMayStart, 1'h1);
        node.setClear(1'h1);
        tick(10);
        check("ctsChange", clear_change_flag, 1'h1);
        check("mayStart", txMayStart, 1'h0);
        check("irq", interruptOut, 1'h1);
        clearChangeClear = 1'h1;
        tick(1);
        clearChangeClear = 1'h0;
        {clear_flow_enable, clear_change_irq_en} = 2'h0;
        node.setClear(1'h0);
        tick(10);
        check("ctsChange", clear_change_flag, 1'h0);
        {tx_buf_empty_flag, tx_dma_enable, transmit_complete_irq_en, txFrameDone} = 4'hF;
        tick(1);
        txFrameDone = 1'h0;
        tick(2);
        check("dmaTx", txDmaRequest, 1'h1);
        check("tc", transmit_complete_flag, 1'h1);
        check("irq", interruptOut, 1'h1);
    endtask
    // --------
    // Main sequence
    // --------
    initial begin
        {single_sample_mode, word_length_select, parity_check_enable, parityOdd} = '0;
        {wake_method_select, rx_dma_enable, tx_dma_enable, error_irq_enable} = '0;
        {rx_buf_full_irq_en, parity_error_irq_en, transmit_complete_irq_en} = '0;
        {clear_change_irq_en, request_flow_enable, clear_flow_enable, dataRead} = '0;
        {errorClear, idleClear, muteSet, muteClear, clearChangeClear} = '0;
        {transmitCompleteClear, tx_buf_empty_flag, txFrameDone, nodeAddress} = '0;
        {unit_enable, receiveEnable, oversample8} = 3'h7;
        baudDivider = 16'h0010;
        tick(12);
        rstn = 1'h1;
        tick(1);
        sPlain();
        sErrors();
        sParity();
        sOverrunNine();
        sAddress();
        sIdle();
        sFlowTx();
        results();
    end
endmodule
`default_nettype wire

// ==== tb/ufm_line_node.sv ====
// Far-end serial node: drives the receive line and the clear pin.
// Assumes the receiver takes one oversample tick per clock.
`timescale 1ns/1ps
`default_nettype none
module ufm_line_node #(
    parameter int BIT_CLK = 8
) (
    input wire logic clock,
    input wire logic rtsIn,
    output logic txLine,
    output logic ctsOut
);
    int bitClk = BIT_CLK;
    initial begin
        txLine = 1'h1;
        ctsOut = 1'h0;
    end
    // --------
    // Frame out
    // --------
    // LSB first, two idle bits after the stop bit; glitch hits one vote sample
    // Glitch lasts two clocks, else the pin synchroniser filters it out
    task automatic sendFrame(input logic [8:0] word, input int nBits, input logic stopLvl,
            input int glitchBit);
        logic lvl;
        while (rtsIn) @(posedge clock);
        for (int i = 0; i < nBits + 4; i++) begin
            lvl = (i == 0) ? 1'h0 : (i <= nBits) ? word[i - 1] : (i == nBits + 1) ? stopLvl : 1'h1;
            for (int c = 0; c < bitClk; c++) begin
                @(posedge clock);
                #1;
                txLine = lvl ^ (i == glitchBit && (c == 2 || c == 3));
            end
        end
    endtask
    task automatic setClear(input logic lvl);
        @(posedge clock);
        #1;
        ctsOut = lvl;
    endtask
endmodule
`default_nettype wire

// ==== tb/ufm_rx_monitor.sv ====
// Concurrent checks on the receiver ports.
// Assumes binding into the receiver; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module ufm_rx_monitor (
    input wire logic clock,
    input wire logic rstn,
    input wire logic clear_to_send_in,
    input wire logic single_sample_mode,
    input wire logic rx_dma_enable,
    input wire logic rx_buf_full_irq_en,
    input wire logic request_flow_enable,
    input wire logic clear_flow_enable,
    input wire logic dataRead,
    input wire logic rx_buf_full_flag,
    input wire logic noise_error_flag,
    input wire logic parity_error_flag,
    input wire logic framing_error_flag,
    input wire logic idle_detected_flag,
    input wire logic mute_request,
    input wire logic request_to_send_out,
    input wire logic clear_change_flag,
    input wire logic txMayStart,
    input wire logic rxDmaRequest,
    input wire logic interruptOut
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    // --------
    // Assertions
    // --------
    err_with_full_a: assert property (
        $rose(noise_error_flag || parity_error_flag || framing_error_flag)
        |-> $rose(rx_buf_full_flag)) else $error("error flag without buffer full");
    read_clears_a: assert property (
        $fell(rx_buf_full_flag) |-> $past(dataRead)) else $error("full dropped without read");
    rts_tracks_a: assert property (
        request_flow_enable && $past(request_flow_enable)
        |-> request_to_send_out == rx_buf_full_flag) else $error("request out wrong");
    dma_tracks_a: assert property (
        rx_dma_enable && $past(rx_dma_enable) |-> rxDmaRequest == rx_buf_full_flag)
        else $error("receive dma request wrong");
    one_sample_a: assert property (
        single_sample_mode && $past(single_sample_mode) |-> !$rose(noise_error_flag))
        else $error("noise flag in single sample mode");
    mute_quiet_a: assert property (
        mute_request |-> !$rose(rx_buf_full_flag || framing_error_flag))
        else $error("status set while muted");
    idle_wake_a: assert property (
        $fell(mute_request) |-> !$rose(idle_detected_flag)) else $error("idle flag on wake");
    clear_toggle_a: assert property (
        clear_flow_enable && $changed(clear_to_send_in) |-> ##[1:8] clear_change_flag)
        else $error("clear toggle not flagged");
    clear_blocks_a: assert property (
        (clear_flow_enable && clear_to_send_in) [*8] |=> !txMayStart)
        else $error("start allowed while clear high");
    full_irq_a: assert property (
        rx_buf_full_irq_en && $past(rx_buf_full_irq_en) && rx_buf_full_flag |-> interruptOut)
        else $error("buffer full interrupt missing");
    // Main scenarios reached
    noisy_c: cover property (rx_buf_full_flag && noise_error_flag);
    woken_c: cover property ($fell(mute_request) && rx_buf_full_flag);
    paused_c: cover property (clear_change_flag && !txMayStart);
endmodule
bind ufm_receiver ufm_rx_monitor mon (.*);
`default_nettype wire
